// File: hw/ddr_timing_pkg.sv
package ddr_timing_pkg;

  // register bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_LAT  = 8'h04;
  localparam logic [7:0] OFS_TCK  = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0c;
  localparam logic [7:0] OFS_TRAS = 8'h10;
  localparam logic [7:0] OFS_TWR  = 8'h14;

  // field positions
  localparam int unsigned CTRL_DLL_DIS = 0;
  localparam int unsigned CTRL_BC4_FIX = 1;
  localparam int unsigned LAT_CL_LSB   = 0;
  localparam int unsigned LAT_AL_LSB   = 4;
  localparam int unsigned LAT_CWL_LSB  = 8;
  localparam int unsigned LAT_FLD_W    = 4;
  localparam int unsigned TCK_W        = 20;
  localparam int unsigned STAT_BUSY    = 0;
  localparam int unsigned STAT_EV_LSB  = 1;
  localparam int unsigned EV_N         = 3;

  // reset values
  localparam logic [3:0]       CL_RST  = 4'h6;
  localparam logic [3:0]       AL_RST  = 4'h0;
  localparam logic [3:0]       CWL_RST = 4'h5;
  localparam logic [TCK_W-1:0] TCK_RST = 20'h1e848;

  // timing figures in picoseconds and clock cycles
  localparam logic [31:0] TWR_PS      = 32'h00003a98;
  localparam logic [7:0]  TWR_MIN_CK  = 8'h05;
  localparam logic [31:0] SLOW_TCK_PS = 32'h00009c40;
  localparam logic [31:0] TRAS_PS_DEF = 32'h000088b8;
  localparam logic [31:0] TRFC_PS_DEF = 32'h00027100;
  localparam logic [5:0]  REC_IDX_BL8 = 6'h03;
  localparam logic [5:0]  REC_IDX_BC4 = 6'h01;
  localparam logic [7:0]  RD_AP_DLY   = 8'h04;
  localparam int unsigned PIPE_W      = 40;
  localparam int unsigned BANKS       = 8;

  // command encoding {ras_n, cas_n, we_n} with cs_n low
  typedef enum logic [2:0] {
    CMD_MRS = 3'h0, CMD_REF = 3'h1, CMD_PRE = 3'h2, CMD_ACT = 3'h3,
    CMD_WR  = 3'h4, CMD_RD  = 3'h5, CMD_ZQ  = 3'h6, CMD_NOP = 3'h7
  } cmd_t;

  function automatic cmd_t decode(input logic cs_n, input logic [2:0] rcw);
    if (cs_n) return CMD_NOP;
    return cmd_t'(rcw);
  endfunction : decode

  // round-up division, a zero period yields one cycle
  function automatic logic [31:0] ceil_div(input logic [31:0] num,
                                           input logic [31:0] den);
    if (den == 32'h0) return 32'h1;
    return (num + den - 32'h1) / den;
  endfunction : ceil_div

  function automatic logic [7:0] sat8(input logic [31:0] v);
    return (v > 32'h000000ff) ? 8'hff : v[7:0];
  endfunction : sat8

endpackage : ddr_timing_pkg

// File: hw/ddr_sync2.sv
// two-flop level synchroniser, no reset: it only carries levels
module ddr_sync2 #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_t;

  sync_t q;
  sync_t d;

  // first stage feeds only the second stage
  always_comb begin
    d    = q;
    d.s1 = din;
    d.s2 = q.s1;
  end

  always_ff @(posedge clk) begin
    q <= d;
  end

  assign dout = q.s2;

endmodule : ddr_sync2

// File: hw/ddr_cmd_timing.sv
// Overview of operation
// - dll off: strobe window starts cl+al-1 cycles after a read, at least one
// - time parameters become cycles by rounding up over the clock period
// - auto precharge waits until minimum row-active time has elapsed
// - write recovery starts wl+4 for bl8/otf bc4, wl+2 for fixed bc4
//
// Added by the designer: the strobed register port and the placing of the registers.
module ddr_cmd_timing #(
  parameter logic [31:0] TRAS_PS = ddr_timing_pkg::TRAS_PS_DEF,
  parameter logic [31:0] TRFC_PS = ddr_timing_pkg::TRFC_PS_DEF
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic      [31:0] rdata,
  input  wire logic        ck,
  input  wire logic        cs_n,
  input  wire logic        ras_n,
  input  wire logic        cas_n,
  input  wire logic        we_n,
  input  wire logic [2:0]  ba,
  input  wire logic        a10,
  input  wire logic        dll_locked,
  output logic             rd_win_start,
  output logic             wr_rec_start,
  output logic             int_pre,
  output logic      [2:0]  int_pre_bank
);

  localparam int unsigned PW = ddr_timing_pkg::PIPE_W;
  localparam int unsigned NB = ddr_timing_pkg::BANKS;
  localparam int unsigned NE = ddr_timing_pkg::EV_N;
  localparam int unsigned TW = ddr_timing_pkg::TCK_W;

  // register side state
  typedef struct packed {
    logic          dll_dis;
    logic          bc4_fix;
    logic [3:0]    cl;
    logic [3:0]    al;
    logic [3:0]    cwl;
    logic [TW-1:0] tck;
    logic          cfg_tog;
    logic          busy;
    logic [NE-1:0] sticky;
    logic [NE-1:0] ev_seen;
    logic [31:0]   rdata;
  } cs_t;

  // link side state
  typedef struct packed {
    logic                 cfg_seen;
    logic                 dll_dis;
    logic [5:0]           rd_lat;
    logic [5:0]           rec_idx;
    logic [7:0]           al;
    logic [7:0]           tras;
    logic [7:0]           twr;
    logic                 slow;
    logic                 refgap;
    logic [PW-1:0]        rd_pipe;
    logic [PW-1:0]        wr_pipe;
    logic [NB-1:0][7:0]   ras;
    logic [NB-1:0][7:0]   apw;
    logic [NB-1:0]        ap_pend;
    logic                 ref_last;
    logic                 ref_pend;
    logic [NE-1:0]        ev_tog;
    logic                 win;
    logic                 rec;
    logic                 pre;
    logic [2:0]           pre_bank;
  } ks_t;

  // busy and cfg_tog start set so the link side loads defaults after reset
  localparam cs_t CS_RST = '{cl: ddr_timing_pkg::CL_RST, al: ddr_timing_pkg::AL_RST,
                             cwl: ddr_timing_pkg::CWL_RST, tck: ddr_timing_pkg::TCK_RST,
                             cfg_tog: 1'b1, busy: 1'b1, default: '0};

  cs_t cq;
  cs_t cd;
  ks_t kq;
  ks_t kd;

  logic [NE:0]   csync;
  logic [2:0]    ksync;
  logic          rst_k;
  logic [7:0]    tras_c;
  logic [7:0]    twr_c;
  logic [31:0]   twr_raw;
  ddr_timing_pkg::cmd_t cmd;

  // ack and event toggles into the register clock
  ddr_sync2 #(.W(NE + 1)) u_sync_c (
    .clk  (clk),
    .din  ({kq.cfg_seen, kq.ev_tog}),
    .dout (csync)
  );

  // reset, cfg toggle and dll lock into the link clock
  ddr_sync2 #(.W(3)) u_sync_k (
    .clk  (ck),
    .din  ({dll_locked, cq.cfg_tog, rst}),
    .dout (ksync)
  );

  assign rst_k = ksync[0];

  // derived cycle counts, stable while the handshake is open
  always_comb begin
    tras_c  = ddr_timing_pkg::sat8(ddr_timing_pkg::ceil_div(TRAS_PS, 32'(cq.tck)));
    twr_raw = ddr_timing_pkg::ceil_div(ddr_timing_pkg::TWR_PS, 32'(cq.tck));
    twr_c   = ddr_timing_pkg::sat8(twr_raw);
    if (cq.dll_dis && twr_c < ddr_timing_pkg::TWR_MIN_CK) begin
      twr_c = ddr_timing_pkg::TWR_MIN_CK;
    end
  end

  // register slave; config writes are refused while a transfer is open
  always_comb begin
    cd       = cq;
    cd.rdata = '0;
    if (cq.busy && csync[NE] == cq.cfg_tog) begin
      cd.busy = 1'b0;
    end
    if (wr_en) begin
      unique case (addr)
        ddr_timing_pkg::OFS_CTRL: begin
          if (!cq.busy) begin
            cd.dll_dis = wdata[ddr_timing_pkg::CTRL_DLL_DIS];
            cd.bc4_fix = wdata[ddr_timing_pkg::CTRL_BC4_FIX];
            cd.cfg_tog = ~cq.cfg_tog;
            cd.busy    = 1'b1;
          end
        end
        ddr_timing_pkg::OFS_LAT: begin
          if (!cq.busy) begin
            cd.cl      = wdata[ddr_timing_pkg::LAT_CL_LSB +: ddr_timing_pkg::LAT_FLD_W];
            cd.al      = wdata[ddr_timing_pkg::LAT_AL_LSB +: ddr_timing_pkg::LAT_FLD_W];
            cd.cwl     = wdata[ddr_timing_pkg::LAT_CWL_LSB +: ddr_timing_pkg::LAT_FLD_W];
            cd.cfg_tog = ~cq.cfg_tog;
            cd.busy    = 1'b1;
          end
        end
        ddr_timing_pkg::OFS_TCK: begin
          if (!cq.busy) begin
            cd.tck     = wdata[TW-1:0];
            cd.cfg_tog = ~cq.cfg_tog;
            cd.busy    = 1'b1;
          end
        end
        ddr_timing_pkg::OFS_STAT: begin
          cd.sticky = cq.sticky & ~wdata[ddr_timing_pkg::STAT_EV_LSB +: NE];
        end
        default: ;
      endcase
    end
    // a new event wins over a clear in the same cycle
    for (int i = 0; i < NE; i++) begin
      if (csync[i] != cq.ev_seen[i]) begin
        cd.sticky[i] = 1'b1;
      end
    end
    cd.ev_seen = csync[NE-1:0];
    if (rd_en) begin
      unique case (addr)
        ddr_timing_pkg::OFS_CTRL: begin
          cd.rdata[ddr_timing_pkg::CTRL_DLL_DIS] = cq.dll_dis;
          cd.rdata[ddr_timing_pkg::CTRL_BC4_FIX] = cq.bc4_fix;
        end
        ddr_timing_pkg::OFS_LAT: begin
          cd.rdata[ddr_timing_pkg::LAT_CL_LSB +: ddr_timing_pkg::LAT_FLD_W]  = cq.cl;
          cd.rdata[ddr_timing_pkg::LAT_AL_LSB +: ddr_timing_pkg::LAT_FLD_W]  = cq.al;
          cd.rdata[ddr_timing_pkg::LAT_CWL_LSB +: ddr_timing_pkg::LAT_FLD_W] = cq.cwl;
        end
        ddr_timing_pkg::OFS_TCK:  cd.rdata[TW-1:0] = cq.tck;
        ddr_timing_pkg::OFS_STAT: begin
          cd.rdata[ddr_timing_pkg::STAT_BUSY]           = cq.busy;
          cd.rdata[ddr_timing_pkg::STAT_EV_LSB +: NE]   = cq.sticky;
        end
        ddr_timing_pkg::OFS_TRAS: cd.rdata[7:0] = tras_c;
        ddr_timing_pkg::OFS_TWR:  cd.rdata[7:0] = twr_c;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    cq <= rst ? CS_RST : cd;
  end

  assign rdata = cq.rdata;

  // link side: capture config, delay lines, bank timers, command checks
  always_comb begin
    logic       found;
    logic [5:0] sum;
    found      = 1'b0;
    sum        = 6'({2'h0, cq.cl} + {2'h0, cq.al});
    cmd        = ddr_timing_pkg::decode(cs_n, {ras_n, cas_n, we_n});
    kd         = kq;
    kd.win     = kq.rd_pipe[0];
    kd.rec     = kq.wr_pipe[0];
    kd.rd_pipe = kq.rd_pipe >> 1;
    kd.wr_pipe = kq.wr_pipe >> 1;
    kd.pre     = 1'b0;
    if (ksync[1] != kq.cfg_seen) begin
      kd.cfg_seen = ksync[1];
      kd.dll_dis  = cq.dll_dis;
      kd.rd_lat   = (sum <= 6'h01) ? 6'h01 : sum - 6'h01;
      kd.rec_idx  = 6'({2'h0, cq.cwl} + {2'h0, cq.al}) +
                    (cq.bc4_fix ? ddr_timing_pkg::REC_IDX_BC4
                                : ddr_timing_pkg::REC_IDX_BL8);
      kd.al       = {4'h0, cq.al};
      kd.tras     = tras_c;
      kd.twr      = twr_c;
      kd.slow     = 32'(cq.tck) > ddr_timing_pkg::SLOW_TCK_PS;
      kd.refgap   = 32'(cq.tck) > TRFC_PS;
    end
    for (int b = 0; b < NB; b++) begin
      if (kq.ras[b] != 8'h00) kd.ras[b] = kq.ras[b] - 8'h01;
      if (kq.apw[b] != 8'h00) kd.apw[b] = kq.apw[b] - 8'h01;
    end
    // lowest ready bank first; one internal precharge per cycle
    for (int b = 0; b < NB; b++) begin
      if (!found && kq.ap_pend[b] && kq.ras[b] == 8'h00 && kq.apw[b] == 8'h00) begin
        found         = 1'b1;
        kd.pre        = 1'b1;
        kd.pre_bank   = 3'(b);
        kd.ap_pend[b] = 1'b0;
      end
    end
    if (kq.ref_pend && cmd != ddr_timing_pkg::CMD_NOP) begin
      kd.ref_pend = 1'b0;
      if (!(cmd == ddr_timing_pkg::CMD_PRE && a10)) kd.ev_tog[2] = ~kq.ev_tog[2];
    end
    kd.ref_last = (cmd == ddr_timing_pkg::CMD_REF);
    unique case (cmd)
      ddr_timing_pkg::CMD_ACT: begin
        kd.ras[ba] = (kq.tras == 8'h00) ? 8'h00 : kq.tras - 8'h01;
      end
      ddr_timing_pkg::CMD_RD: begin
        if (kq.dll_dis) kd.rd_pipe[kq.rd_lat - 6'h01] = 1'b1;
        if (!ksync[2]) kd.ev_tog[0] = ~kq.ev_tog[0];
        if (a10) begin
          kd.ap_pend[ba] = 1'b1;
          kd.apw[ba]     = kq.al + ddr_timing_pkg::RD_AP_DLY;
        end
      end
      ddr_timing_pkg::CMD_WR: begin
        kd.wr_pipe[kq.rec_idx] = 1'b1;
        if (a10) begin
          kd.ap_pend[ba] = 1'b1;
          kd.apw[ba]     = ddr_timing_pkg::sat8(32'(kq.rec_idx) + 32'h1 + 32'(kq.twr));
        end
      end
      ddr_timing_pkg::CMD_REF: begin
        if (kq.ref_last && kq.refgap) kd.ev_tog[1] = ~kq.ev_tog[1];
        kd.ref_pend = kq.slow;
      end
      default: ;
    endcase
  end

  // sync reset: the link clock must run while rst is high
  always_ff @(posedge ck) begin
    kq <= rst_k ? '0 : kd;
  end

  assign rd_win_start = kq.win;
  assign wr_rec_start = kq.rec;
  assign int_pre      = kq.pre;
  assign int_pre_bank = kq.pre_bank;

  // independent history for the checks below
  logic [PW:0]        hist_rd;
  logic [PW:0]        hist_wr;
  logic [NB-1:0][7:0] age;
  logic [NB-1:0]      ap_prev;
  // ap_prev keeps the pending mask per bank, so the bank index is not taken from the past
  always_ff @(posedge ck) begin
    if (rst_k) begin
      hist_rd <= '0;
      hist_wr <= '0;
      age     <= '0;
      ap_prev <= '0;
    end else begin
      ap_prev <= kq.ap_pend;
      hist_rd <= {hist_rd[PW-1:0], cmd == ddr_timing_pkg::CMD_RD && kq.dll_dis};
      hist_wr <= {hist_wr[PW-1:0], cmd == ddr_timing_pkg::CMD_WR};
      for (int b = 0; b < NB; b++) begin
        if (cmd == ddr_timing_pkg::CMD_ACT && ba == 3'(b)) age[b] <= 8'h01;
        else if (age[b] != 8'hff) age[b] <= age[b] + 8'h01;
      end
    end
  end

  sequence s_read_dll_off;
    cmd == ddr_timing_pkg::CMD_RD && kq.dll_dis && ksync[1] == kq.cfg_seen;
  endsequence

  AST_RD_WIN_CAUSE: assert property (@(posedge ck) disable iff (rst_k)
    rd_win_start |-> hist_rd[kq.rd_lat])
    else $error("read window start without read cl+al-1 cycles before");

  AST_RD_WIN_LAT: assert property (@(posedge ck) disable iff (rst_k)
    s_read_dll_off ##1 (kq.rd_lat == 6'h01) |=> rd_win_start)
    else $error("read window not started one cycle after read at latency one");

  AST_WR_REC_CAUSE: assert property (@(posedge ck) disable iff (rst_k)
    wr_rec_start |-> hist_wr[kq.rec_idx + 6'h01])
    else $error("write recovery start not at wl plus offset");

  AST_AP_TRAS: assert property (@(posedge ck) disable iff (rst_k)
    int_pre |-> age[int_pre_bank] > kq.tras)
    else $error("internal precharge before minimum row-active time");

  AST_AP_PEND: assert property (@(posedge ck) disable iff (rst_k)
    int_pre |-> ap_prev[int_pre_bank] && !kq.ap_pend[int_pre_bank])
    else $error("internal precharge without pending auto precharge");

  AST_TRAS_RU: assert property (@(posedge clk) disable iff (rst)
    (cq.tck != '0 && tras_c != 8'hff) |->
      (32'(tras_c) * 32'(cq.tck) >= TRAS_PS) &&
      ((32'(tras_c) - 32'h1) * 32'(cq.tck) < TRAS_PS))
    else $error("row-active cycles not rounded up");

  AST_TWR_MIN: assert property (@(posedge clk) disable iff (rst)
    (cq.dll_dis && cq.tck != '0) |-> twr_c >= ddr_timing_pkg::TWR_MIN_CK &&
      (twr_c == 8'hff || 32'(twr_c) * 32'(cq.tck) >= ddr_timing_pkg::TWR_PS))
    else $error("write recovery below 5 cycles or 15 ns with dll off");

  AST_DLL_READ: assert property (@(posedge ck) disable iff (rst_k)
    (cmd == ddr_timing_pkg::CMD_RD && !ksync[2]) |=> $changed(kq.ev_tog[0]))
    else $error("read with dll unlocked not reported");

endmodule : ddr_cmd_timing

// File: verif/ctrl_model.sv
// controller side of the command link, behavioural
module ctrl_model (
  input  wire logic       ck,
  output logic            cs_n,
  output logic            ras_n,
  output logic            cas_n,
  output logic            we_n,
  output logic      [2:0] ba,
  output logic            a10,
  output logic            dll_locked
);
  timeunit 1ns;
  timeprecision 1ps;

  // start deselected with the lock up
  initial begin
    cs_n = 1'b1;
    {ras_n, cas_n, we_n} = 3'h7;
    ba = 3'h0;
    a10 = 1'b0;
    dll_locked = 1'b1;
  end

  // driven after an edge, taken at the next; back to back calls leave no gap
  task automatic issue(input ddr_timing_pkg::cmd_t c, input logic [2:0] b, input logic a);
    @(posedge ck);
    cs_n <= 1'b0;
    {ras_n, cas_n, we_n} <= c;
    ba <= b;
    a10 <= a;
  endtask : issue

  // deselect; the other pins flip so a stale command never lingers
  // no cke pin is driven here, only cs_n, the command pins, ba and a10
  task automatic idle();
    @(posedge ck);
    cs_n <= 1'b1;
    {ras_n, cas_n, we_n} <= ~{ras_n, cas_n, we_n};
    ba <= ~ba;
    a10 <= ~a10;
  endtask : idle

  // lock drops only where a scenario asks for it
  task automatic set_lock(input logic l);
    @(posedge ck);
    dll_locked <= l;
  endtask : set_lock
endmodule : ctrl_model

// File: verif/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [31:0] t;
    ddr_timing_pkg::cmd_t c;
    bit g;
    bit a;
    logic [3:0] e;
  } row_t;
  logic        clk, rst, ck, wr_en, rd_en;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata;
  logic        cs_n, ras_n, cas_n, we_n, a10, dll_locked;
  logic        rd_win_start, wr_rec_start, int_pre;
  logic [2:0]  ba, int_pre_bank;
  int          error_cnt = 0;
  int          total_checks = 0;
  int          seed = 32'h1ff2eb71;

  // two unrelated clocks
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    ck = 1'b0;
    #7;
    forever #62.5 ck = ~ck;
  end

  ddr_cmd_timing DUT (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .ck(ck), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .ba(ba), .a10(a10), .dll_locked(dll_locked), .rd_win_start(rd_win_start),
    .wr_rec_start(wr_rec_start), .int_pre(int_pre), .int_pre_bank(int_pre_bank));
  ctrl_model ctrl (.ck(ck), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba),
    .a10(a10), .dll_locked(dll_locked));

  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_delay(input int got, input int exp);
    total_checks++;
    if (got != exp) begin
      error_cnt++;
      $display("unexpected at %0t: delay %h exp %h", $time, got, exp);
    end
  endtask : chk_delay

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : reg_wr

  // read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    d = rdata;
  endtask : reg_rd

  // config write, then poll busy so the link side has the new setting
  task automatic cfg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] s;
    if (a != 8'hff) reg_wr(a, d);
    for (int i = 0; i < 200; i++) begin
      reg_rd(ddr_timing_pkg::OFS_STAT, s);
      if (s[0] === 1'b0) break;
    end
    chk_word({31'h0, s[0]}, 32'h0);
  endtask : cfg

  // sticky flags need a few cycles to cross; clear after the look
  task automatic st_chk(input logic [31:0] exp);
    logic [31:0] s;
    repeat (4) @(posedge ck);
    reg_rd(ddr_timing_pkg::OFS_STAT, s);
    chk_word(s & 32'he, exp);
    reg_wr(ddr_timing_pkg::OFS_STAT, 32'he);
  endtask : st_chk

  // counts link edges from the command edge to the chosen pulse
  task automatic wait_pulse(input int sel, output int n);
    logic [2:0] p;
    for (n = 1; n <= 60; n++) begin
      @(posedge ck);
      #1;
      p = {int_pre, wr_rec_start, rd_win_start};
      if (p[sel] === 1'b1) break;
    end
  endtask : wait_pulse

  function automatic logic [31:0] cyc(input logic [31:0] ps, input logic [31:0] t);
    logic [31:0] n;
    n = (ps + t - 32'h1) / t;
    return (n > 32'hff) ? 32'hff : n;
  endfunction : cyc

  // watchdog, far beyond the expected run
  initial begin
    #2000000;
    error_cnt++;
    finish_test();
  end

  initial begin
    logic [31:0] d, t, w;
    logic [2:0]  b;
    int          n, cl, al, cwl, bc;
    logic [7:0]  ra [7] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h20, 8'h0c};
    logic [31:0] re [7] = '{32'h0, 32'h506, 32'h1e848, 32'h1, 32'h1, 32'h0, 32'h0};
    logic [31:0] tc [4] = '{32'hbb8, 32'h3a98, 32'h88b9, 32'h1};
    row_t rows [10] = '{'{32'h30d40, ddr_timing_pkg::CMD_REF, 0, 0, 4'hc},
      '{32'h30d40, ddr_timing_pkg::CMD_REF, 1, 0, 4'h8},
      '{32'h30d40, ddr_timing_pkg::CMD_PRE, 0, 1, 4'h0},
      '{32'h30d40, ddr_timing_pkg::CMD_PRE, 0, 0, 4'h8},
      '{32'h30d40, ddr_timing_pkg::CMD_ACT, 1, 0, 4'h8},
      '{32'h7530, ddr_timing_pkg::CMD_REF, 0, 0, 4'h0},
      '{32'h7530, ddr_timing_pkg::CMD_ACT, 0, 0, 4'h0},
      '{32'h9c40, ddr_timing_pkg::CMD_ACT, 0, 0, 4'h0},
      '{32'h9c41, ddr_timing_pkg::CMD_ACT, 0, 0, 4'h8},
      '{32'h27100, ddr_timing_pkg::CMD_REF, 0, 0, 4'h8}};
    rst = 1'b1;
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 8'h0;
    wdata = 32'h0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    // reset values, an unmapped word and a read-only one
    cfg(8'hff, 32'h0);
    reg_wr(8'h20, 32'hffffffff);
    reg_wr(ddr_timing_pkg::OFS_TRAS, 32'hff);
    foreach (ra[i]) begin
      reg_rd(ra[i], d);
      chk_word(d, re[i]);
    end
    // rounding of time figures, corners first then random periods
    for (int i = 0; i < 10; i++) begin
      t = (i < 4) ? tc[i] : ($random(seed) & 32'hfffff) | 32'h1;
      bc = $random(seed) & 1;
      cfg(ddr_timing_pkg::OFS_CTRL, bc);
      cfg(ddr_timing_pkg::OFS_TCK, t);
      w = cyc(ddr_timing_pkg::TWR_PS, t);
      if (bc == 1 && w < 32'h5) w = 32'h5;
      reg_rd(ddr_timing_pkg::OFS_TRAS, d);
      chk_word(d, cyc(ddr_timing_pkg::TRAS_PS_DEF, t));
      reg_rd(ddr_timing_pkg::OFS_TWR, d);
      chk_word(d, w);
    end
    // strobe window and write recovery start over random latencies
    for (int i = 0; i < 8; i++) begin
      cl = (i == 0) ? 1 : 1 + ($unsigned($random(seed)) % 15);
      al = (i == 0) ? 0 : $unsigned($random(seed)) % 8;
      cwl = 5 + ($unsigned($random(seed)) % 8);
      bc = i % 2;
      cfg(ddr_timing_pkg::OFS_CTRL, {30'h0, bc[0], 1'b1});
      cfg(ddr_timing_pkg::OFS_LAT, (cwl << 8) | (al << 4) | cl);
      ctrl.issue(ddr_timing_pkg::CMD_RD, 3'h0, 1'b0);
      ctrl.idle();
      wait_pulse(0, n);
      chk_delay(n, (cl + al - 1 < 1) ? 1 : cl + al - 1);
      ctrl.issue(ddr_timing_pkg::CMD_WR, 3'h0, 1'b0);
      ctrl.idle();
      wait_pulse(1, n);
      chk_delay(n, cwl + al + (bc ? 2 : 4));
    end
    // auto precharge right behind the activate must wait out 14 cycles
    cfg(ddr_timing_pkg::OFS_TCK, 32'h9c4);
    b = 3'($random(seed));
    ctrl.issue(ddr_timing_pkg::CMD_ACT, b, 1'b0);
    ctrl.issue(ddr_timing_pkg::CMD_RD, b, 1'b1);
    ctrl.idle();
    wait_pulse(2, n);
    chk_word({31'h0, n + 1 >= 14 && n <= ((al + 4 > 13) ? al + 4 : 13) + 3}, 32'h1);
    chk_word({29'h0, int_pre_bank}, {29'h0, b});
    // a read with the lock lost is flagged, with it held not
    for (int l = 0; l < 2; l++) begin
      ctrl.set_lock(l[0]);
      repeat (4) @(posedge ck);
      ctrl.issue(ddr_timing_pkg::CMD_RD, 3'h0, 1'b0);
      ctrl.idle();
      ctrl.set_lock(1'b1);
      st_chk(l ? 32'h0 : 32'h2);
    end
    // refresh spacing and precharge-all after refresh at slow clocks
    foreach (rows[i]) begin
      cfg(ddr_timing_pkg::OFS_TCK, rows[i].t);
      // every scenario opens with a refresh; the run is far shorter than any refresh window
      ctrl.issue(ddr_timing_pkg::CMD_REF, 3'h0, 1'b0);
      if (rows[i].g) ctrl.idle();
      ctrl.issue(rows[i].c, 3'h0, rows[i].a);
      ctrl.issue(ddr_timing_pkg::CMD_PRE, 3'h0, 1'b1);
      ctrl.idle();
      st_chk({28'h0, rows[i].e});
    end
    finish_test();
  end
endmodule : testbench
